// ==== hdl/pag_pkg.sv ====
// shared constants, types and functions of the access guard
package pag_pkg;

  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] IDX_MASTER_PRIVILEGE = 8'h20;
  localparam logic [7:0] IDX_PERIPH_ACCESS_0  = 8'h24;
  localparam logic [7:0] IDX_PERIPH_ACCESS_1  = 8'h25;
  localparam logic [7:0] IDX_PERIPH_ACCESS_2  = 8'h26;
  localparam logic [7:0] IDX_PERIPH_ACCESS_3  = 8'h27;
  localparam logic [7:0] IDX_PERIPH_ACCESS_4  = 8'h28;
  localparam logic [7:0] IDX_PERIPH_ACCESS_5  = 8'h2a;
  localparam logic [7:0] IDX_PERIPH_ACCESS_6  = 8'h2b;
  localparam logic [7:0] IDX_PERIPH_ACCESS_7  = 8'h2c;
  localparam logic [7:0] IDX_PERIPH_ACCESS_8  = 8'h2e;
  localparam logic [7:0] IDX_GROUP_ACCESS_0   = 8'h30;
  localparam logic [7:0] IDX_GROUP_ACCESS_1   = 8'h31;
  localparam logic [7:0] IDX_IRQ_STATUS       = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK         = 8'h41;

  // ************************************************************
  // field layout and reset values
  // ************************************************************
  localparam int         NUM_MASTERS      = 4;
  localparam int         NUM_PERIPH_REGS  = 9;
  localparam int         NUM_SLOTS        = 18;
  localparam int         UPPER_LOCK_BIT   = 7;
  localparam int         UPPER_RIGHTS_LSB = 4;
  localparam int         LOWER_LOCK_BIT   = 3;
  localparam int         LOWER_RIGHTS_LSB = 0;
  localparam int         GROUP_LOCK_BIT   = 7;
  localparam int         EVT_VIOLATION    = 0;
  localparam int         EVT_REFUSED      = 1;
  localparam int         NUM_EVENTS       = 2;
  localparam logic [3:0] MASTER_PRIV_RST  = 4'h1;
  localparam logic [7:0] PERIPH_RST       = 8'h00;
  localparam logic [7:0] GROUP_RST        = 8'h00;
  localparam logic [7:0] GROUP_WR_MASK    = 8'h8f;
  localparam logic [3:0] REGION_GROUP_0   = 4'h0;
  localparam logic [3:0] REGION_GROUP_1   = 4'h1;
  localparam logic [3:0] PERIPH_NONE      = 4'hf;
  localparam logic [1:0] HTRANS_NONSEQ    = 2'b10;
  localparam logic [2:0] HSIZE_WORD       = 3'b010;

  // rights vector bit positions {sup_r, sup_w, sup_x, usr_r, usr_w, usr_x}
  localparam int RT_SUP_R = 5;
  localparam int RT_SUP_W = 4;
  localparam int RT_SUP_X = 3;
  localparam int RT_USR_R = 2;
  localparam int RT_USR_W = 1;
  localparam int RT_USR_X = 0;

  // register bus handshake states
  typedef enum logic [1:0] {ST_IDLE, ST_WCHK, ST_ERR1, ST_ERR2} pag_bus_state_type;

  // ************************************************************
  // decode functions
  // ************************************************************
  // rights of a code; 3-bit codes have msb zero
  function automatic logic [5:0] pag_rights(input logic [3:0] code);
    case (code)
      4'h0:    pag_rights = 6'h30;
      4'h1:    pag_rights = 6'h20;
      4'h2:    pag_rights = 6'h24;
      4'h3:    pag_rights = 6'h20;
      4'h4:    pag_rights = 6'h36;
      4'h5:    pag_rights = 6'h34;
      4'h6:    pag_rights = 6'h36;
      4'h7:    pag_rights = 6'h00;
      4'h8:    pag_rights = 6'h38;
      4'h9:    pag_rights = 6'h28;
      4'ha:    pag_rights = 6'h2d;
      4'hb:    pag_rights = 6'h08;
      4'hc:    pag_rights = 6'h3f;
      4'hd:    pag_rights = 6'h3d;
      4'he:    pag_rights = 6'h34;
      default: pag_rights = 6'h39;
    endcase
  endfunction : pag_rights

  // periph register number of an index, or none
  function automatic logic [3:0] pag_periph_num(input logic [7:0] idx);
    case (idx)
      IDX_PERIPH_ACCESS_0: pag_periph_num = 4'h0;
      IDX_PERIPH_ACCESS_1: pag_periph_num = 4'h1;
      IDX_PERIPH_ACCESS_2: pag_periph_num = 4'h2;
      IDX_PERIPH_ACCESS_3: pag_periph_num = 4'h3;
      IDX_PERIPH_ACCESS_4: pag_periph_num = 4'h4;
      IDX_PERIPH_ACCESS_5: pag_periph_num = 4'h5;
      IDX_PERIPH_ACCESS_6: pag_periph_num = 4'h6;
      IDX_PERIPH_ACCESS_7: pag_periph_num = 4'h7;
      IDX_PERIPH_ACCESS_8: pag_periph_num = 4'h8;
      default:             pag_periph_num = PERIPH_NONE;
    endcase
  endfunction : pag_periph_num

endpackage : pag_pkg

// ==== hdl/pag_guard.sv ====
// peripheral access guard: privilege checker plus its ahb-lite register file
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/10ps

// Overview of operation
// - references are checked before access; refusals error.
// - six types: super or user by fetch, read, write.
// - check uses carried privilege and code/data attributes.
// - privilege bits 3..0: 0 forces user, 1 passes; 7..4 reserved.
// - master 0 trusted; its privilege bit resets to one.
// - reset straps trust non-core masters, enabling attribute.
// - untrusted register writes error and change nothing.
// - periph register: lock 7, rights 6..4, lock 3, rights 2..0.
// - a set lock makes writes error until reset.
// - 3-bit rights decode to supervisor and user read/write.
// - reset: supervisor read/write only, no user access.
// - fetches to register-governed peripherals error.
// - registers at 0x020, 0x024..0x02e, 0x030 onward.
// - group registers reset to supervisor read/write.
// - address bits 29..26 pick region; only 0 and 1 exist.
// - group register: lock 7, rights 3..0; upper codes except 0xe execute.
module pag_guard (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [1:0]  hmaster,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic [2:0]  trust_strap,
  input  wire logic        chk_valid,
  input  wire logic [1:0]  chk_master,
  input  wire logic        chk_super,
  input  wire logic        chk_fetch,
  input  wire logic        chk_write,
  input  wire logic [3:0]  chk_region,
  input  wire logic        chk_slot_valid,
  input  wire logic [4:0]  chk_slot,
  output logic             chk_done,
  output logic             chk_allow,
  output logic             chk_deny,
  output logic             irq
);

  // ************************************************************
  // state
  // ************************************************************
  pag_pkg::pag_bus_state_type state_q;
  logic [3:0]  master_priv_q;
  logic [3:0]  trusted_q;
  logic        strap_done_q;
  logic [7:0]  periph_access_q [pag_pkg::NUM_PERIPH_REGS];
  logic [7:0]  group_access_q  [2];
  logic [pag_pkg::NUM_EVENTS-1:0] irq_status_q;
  logic [pag_pkg::NUM_EVENTS-1:0] irq_mask_q;
  logic [7:0]  widx_q;
  logic [1:0]  wmaster_q;
  logic        hreadyout_q;
  logic        hresp_q;
  logic [31:0] hrdata_q;
  logic        chk_done_q;
  logic        chk_allow_q;
  logic        chk_deny_q;
  logic        irq_q;

  // combinational helpers
  logic        accept;
  logic [7:0]  aidx;
  logic [7:0]  rd_byte;
  logic [3:0]  wnum;
  logic        wr_locked;
  logic        wr_err;
  logic        wr_ok;
  logic [7:0]  wbyte;
  logic        eff_super;
  logic [3:0]  rights_code;
  logic [5:0]  rights;
  logic        path_ok;
  logic        periph_path;
  logic        allowed;
  logic [pag_pkg::NUM_EVENTS-1:0] evt;
  logic [pag_pkg::NUM_EVENTS-1:0] clr;

  // ************************************************************
  // register bus decode
  // ************************************************************
  // word nonseq transfer taken while ready
  assign accept = hsel && hready && (htrans == pag_pkg::HTRANS_NONSEQ)
                  && (hsize == pag_pkg::HSIZE_WORD);
  assign aidx   = haddr[9:2];
  assign wnum   = pag_pkg::pag_periph_num(widx_q);
  assign wbyte  = hwdata[7:0];

  // register read value; holes read zero
  always_comb
  begin
    rd_byte = 8'h00;
    case (aidx)
      pag_pkg::IDX_MASTER_PRIVILEGE: rd_byte = {4'h0, master_priv_q};
      pag_pkg::IDX_GROUP_ACCESS_0:   rd_byte = group_access_q[0];
      pag_pkg::IDX_GROUP_ACCESS_1:   rd_byte = group_access_q[1];
      pag_pkg::IDX_IRQ_STATUS:       rd_byte = {6'h00, irq_status_q};
      pag_pkg::IDX_IRQ_MASK:         rd_byte = {6'h00, irq_mask_q};
      default:
      begin
        if (pag_pkg::pag_periph_num(aidx) != pag_pkg::PERIPH_NONE)
        begin
          rd_byte = periph_access_q[pag_pkg::pag_periph_num(aidx)];
        end
      end
    endcase
  end

  // lock of the pending write's register
  always_comb
  begin
    wr_locked = 1'b0;
    if (wnum != pag_pkg::PERIPH_NONE)
    begin
      wr_locked = periph_access_q[wnum][pag_pkg::UPPER_LOCK_BIT]
                  || periph_access_q[wnum][pag_pkg::LOWER_LOCK_BIT];
    end
    else if (widx_q == pag_pkg::IDX_GROUP_ACCESS_0)
    begin
      wr_locked = group_access_q[0][pag_pkg::GROUP_LOCK_BIT];
    end
    else if (widx_q == pag_pkg::IDX_GROUP_ACCESS_1)
    begin
      wr_locked = group_access_q[1][pag_pkg::GROUP_LOCK_BIT];
    end
  end

  // refuse untrusted masters and locked registers
  assign wr_err = (state_q == pag_pkg::ST_WCHK)
                  && (!trusted_q[wmaster_q] || wr_locked);
  assign wr_ok  = (state_q == pag_pkg::ST_WCHK) && !wr_err;
  // ************************************************************
  // register bus handshake
  // ************************************************************
  // reads take no wait, writes one; errors take two cycles
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q     <= pag_pkg::ST_IDLE;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      widx_q      <= 8'h00;
      wmaster_q   <= 2'b00;
    end
    else
    begin
      case (state_q)
        pag_pkg::ST_WCHK:
        begin
          if (wr_err)
          begin
            state_q     <= pag_pkg::ST_ERR1;
            hreadyout_q <= 1'b0;
            hresp_q     <= 1'b1;
          end
          else
          begin
            state_q     <= pag_pkg::ST_IDLE;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
          end
        end
        pag_pkg::ST_ERR1:
        begin
          state_q     <= pag_pkg::ST_ERR2;
          hreadyout_q <= 1'b1;
          hresp_q     <= 1'b1;
        end
        default:
        begin
          hresp_q <= 1'b0;
          if (accept && hwrite)
          begin
            state_q     <= pag_pkg::ST_WCHK;
            hreadyout_q <= 1'b0;
            widx_q      <= aidx;
            wmaster_q   <= hmaster;
          end
          else
          begin
            state_q     <= pag_pkg::ST_IDLE;
            hreadyout_q <= 1'b1;
          end
        end
      endcase
    end
  end
  // read data held from the address phase to the next read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_q <= 32'h0000_0000;
    end
    else if (accept && !hwrite && (state_q != pag_pkg::ST_WCHK)
             && (state_q != pag_pkg::ST_ERR1))
    begin
      hrdata_q <= {24'h00_0000, rd_byte};
    end
  end
  // ************************************************************
  // trust straps and master privilege
  // ************************************************************
  // straps load on the first edge after reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      strap_done_q  <= 1'b0;
      trusted_q     <= pag_pkg::MASTER_PRIV_RST;
      master_priv_q <= pag_pkg::MASTER_PRIV_RST;
    end
    else if (!strap_done_q)
    begin
      strap_done_q  <= 1'b1;
      trusted_q     <= {trust_strap, 1'b1};
      master_priv_q <= {trust_strap, 1'b1};
    end
    else if (wr_ok && (widx_q == pag_pkg::IDX_MASTER_PRIVILEGE))
    begin
      master_priv_q <= wbyte[3:0];
    end
  end

  // ************************************************************
  // peripheral and group access registers
  // ************************************************************
  // only reset clears lock bits; locked registers never write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < pag_pkg::NUM_PERIPH_REGS; i++)
      begin
        periph_access_q[i] <= pag_pkg::PERIPH_RST;
      end
    end
    else if (wr_ok && (wnum != pag_pkg::PERIPH_NONE))
    begin
      periph_access_q[wnum] <= wbyte;
    end
  end
  // group registers keep reserved bits 6..4 at zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      group_access_q[0] <= pag_pkg::GROUP_RST;
      group_access_q[1] <= pag_pkg::GROUP_RST;
    end
    else if (wr_ok && (widx_q == pag_pkg::IDX_GROUP_ACCESS_0))
    begin
      group_access_q[0] <= wbyte & pag_pkg::GROUP_WR_MASK;
    end
    else if (wr_ok && (widx_q == pag_pkg::IDX_GROUP_ACCESS_1))
    begin
      group_access_q[1] <= wbyte & pag_pkg::GROUP_WR_MASK;
    end
  end

  // ************************************************************
  // reference check
  // ************************************************************
  // a cleared master bit forces user mode
  assign eff_super = chk_super && master_priv_q[chk_master];
  // governing rights code: a peripheral slot beats its region
  always_comb
  begin
    rights_code = 4'h7;
    path_ok     = 1'b0;
    periph_path = 1'b0;
    if (chk_slot_valid)
    begin
      periph_path = 1'b1;
      if (chk_slot < 5'(pag_pkg::NUM_SLOTS))
      begin
        path_ok = 1'b1;
        if (chk_slot[0])
        begin
          rights_code = {1'b0,
            periph_access_q[chk_slot[4:1]][pag_pkg::LOWER_RIGHTS_LSB +: 3]};
        end
        else
        begin
          rights_code = {1'b0,
            periph_access_q[chk_slot[4:1]][pag_pkg::UPPER_RIGHTS_LSB +: 3]};
        end
      end
    end
    else if (chk_region == pag_pkg::REGION_GROUP_0)
    begin
      path_ok     = 1'b1;
      rights_code = group_access_q[0][3:0];
    end
    else if (chk_region == pag_pkg::REGION_GROUP_1)
    begin
      path_ok     = 1'b1;
      rights_code = group_access_q[1][3:0];
    end
  end
  assign rights = pag_pkg::pag_rights(rights_code);
  // six access types
  always_comb
  begin
    allowed = 1'b0;
    if (path_ok)
    begin
      if (chk_fetch)
      begin
        allowed = !periph_path && (eff_super ? rights[pag_pkg::RT_SUP_X]
                                             : rights[pag_pkg::RT_USR_X]);
      end
      else if (chk_write)
      begin
        allowed = eff_super ? rights[pag_pkg::RT_SUP_W] : rights[pag_pkg::RT_USR_W];
      end
      else
      begin
        allowed = eff_super ? rights[pag_pkg::RT_SUP_R] : rights[pag_pkg::RT_USR_R];
      end
    end
  end
  // verdict one cycle later; the target is reached only on allow
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      chk_done_q  <= 1'b0;
      chk_allow_q <= 1'b0;
      chk_deny_q  <= 1'b0;
    end
    else
    begin
      chk_done_q  <= chk_valid;
      chk_allow_q <= chk_valid && allowed;
      chk_deny_q  <= chk_valid && !allowed;
    end
  end

  // ************************************************************
  // interrupt status and mask
  // ************************************************************
  assign evt[pag_pkg::EVT_VIOLATION] = chk_valid && !allowed;
  assign evt[pag_pkg::EVT_REFUSED]   = wr_err;
  assign clr = (wr_ok && (widx_q == pag_pkg::IDX_IRQ_STATUS))
               ? wbyte[pag_pkg::NUM_EVENTS-1:0] : '0;
  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_status_q <= '0;
    end
    else
    begin
      irq_status_q <= (irq_status_q & ~clr) | evt;
    end
  end
  // mask: a one enables the status bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_mask_q <= '0;
    end
    else if (wr_ok && (widx_q == pag_pkg::IDX_IRQ_MASK))
    begin
      irq_mask_q <= wbyte[pag_pkg::NUM_EVENTS-1:0];
    end
  end
  // level interrupt from unmasked status
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end
  // ************************************************************
  // outputs
  // ************************************************************
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign hrdata    = hrdata_q;
  assign chk_done  = chk_done_q;
  assign chk_allow = chk_allow_q;
  assign chk_deny  = chk_deny_q;
  assign irq       = irq_q;
endmodule : pag_guard

// ==== sim/pag_guard_asserts.sv ====
// checker on the access guard ports
`timescale 1ns/10ps
module pag_guard_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        chk_valid,
  input wire logic        chk_fetch,
  input wire logic [3:0]  chk_region,
  input wire logic        chk_slot_valid,
  input wire logic        chk_done,
  input wire logic        chk_allow,
  input wire logic        chk_deny
);
  logic taken;

  // a register transfer accepted at this edge
  assign taken = hsel && hready && htrans == pag_pkg::HTRANS_NONSEQ
                 && hsize == pag_pkg::HSIZE_WORD;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ************************************************************
  // properties
  // ************************************************************
  done_follows_a: assert property (chk_valid |=> chk_done)
    else $error("no verdict");
  answer_one_a: assert property (chk_done |-> chk_allow != chk_deny)
    else $error("verdict not one-hot");
  no_stray_a: assert property ((chk_allow || chk_deny) |-> chk_done && $past(chk_valid))
    else $error("stray verdict");
  fetch_slot_a: assert property (chk_valid && chk_fetch && chk_slot_valid |=> chk_deny)
    else $error("fetch not denied");
  region_deny_a: assert property (chk_valid && !chk_slot_valid && chk_region > 4'h1
    |=> chk_deny)
    else $error("region not denied");
  read_nowait_a: assert property (taken && !hwrite |=> hreadyout && !hresp)
    else $error("read waited");
  write_wait_a: assert property (taken && hwrite |=> !hreadyout && !hresp
    ##1 (hreadyout ^ hresp))
    else $error("write handshake wrong");
  err_two_a: assert property ($rose(hresp) |-> !hreadyout ##1 (hresp && hreadyout)
    ##1 (!hresp && hreadyout))
    else $error("error not two cycles");
endmodule : pag_guard_chk

// ==== sim/pag_master_model.sv ====
// bus-master model issuing references
`timescale 1ns/10ps
module pag_master_model (
  input  wire logic       hclk,
  output logic            chk_valid,
  output logic [1:0]      chk_master,
  output logic            chk_super,
  output logic            chk_fetch,
  output logic            chk_write,
  output logic [3:0]      chk_region,
  output logic            chk_slot_valid,
  output logic [4:0]      chk_slot,
  input  wire logic       chk_done,
  input  wire logic       chk_allow,
  input  wire logic       chk_deny
);
  logic [14:0] attr;

  // idle at time zero; attributes travel as one word
  initial
  begin
    chk_valid = 1'b0;
    attr      = '0;
  end
  assign {chk_master, chk_super, chk_fetch, chk_write, chk_region, chk_slot_valid,
          chk_slot} = attr;

  // one reference; answer is {done, allow, deny}
  task automatic issue(input logic [1:0] m, input logic s, input logic f, input logic w,
                       input logic [3:0] rg, input logic sv, input logic [4:0] sl,
                       output logic [2:0] ans);
    @(posedge hclk);
    chk_valid <= 1'b1;
    attr      <= {m, s, f, w, rg, sv, sl};
    @(posedge hclk);
    chk_valid <= 1'b0;
    attr      <= ~{m, s, f, w, rg, sv, sl}; // released attributes inverted
    #1;
    ans = {chk_done, chk_allow, chk_deny};
  endtask : issue
endmodule : pag_master_model

// ==== sim/pag_guard_tb.sv ====
// testbench for the access guard
`timescale 1ns/10ps
module pag_guard_tb;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, hmaster, chk_master;
  logic [2:0]  hsize, trust_strap;
  logic        chk_valid, chk_super, chk_fetch, chk_write, chk_slot_valid;
  logic        chk_done, chk_allow, chk_deny;
  logic [3:0]  chk_region;
  logic [4:0]  chk_slot;
  int          n_errors, compares;
  // expected rights per code
  localparam logic [3:0] PA_EXP [8]  = '{4'hc, 4'h8, 4'ha, 4'h8, 4'hf, 4'he, 4'hf, 4'h0};
  localparam logic [5:0] GP_EXP [16] = '{6'h30, 6'h20, 6'h24, 6'h20, 6'h36, 6'h34, 6'h36,
    6'h00, 6'h38, 6'h28, 6'h2d, 6'h08, 6'h3f, 6'h3d, 6'h34, 6'h39};
  localparam logic [7:0] REGS [12] = '{8'h20, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h2a,
    8'h2b, 8'h2c, 8'h2e, 8'h30, 8'h31};

  assign hready = hreadyout;

  pag_guard DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hmaster(hmaster), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .trust_strap(trust_strap), .chk_valid(chk_valid), .chk_master(chk_master),
    .chk_super(chk_super), .chk_fetch(chk_fetch), .chk_write(chk_write),
    .chk_region(chk_region), .chk_slot_valid(chk_slot_valid), .chk_slot(chk_slot),
    .chk_done(chk_done), .chk_allow(chk_allow), .chk_deny(chk_deny), .irq(irq));

  pag_master_model u_mst (.hclk(hclk), .chk_valid(chk_valid), .chk_master(chk_master),
    .chk_super(chk_super), .chk_fetch(chk_fetch), .chk_write(chk_write),
    .chk_region(chk_region), .chk_slot_valid(chk_slot_valid), .chk_slot(chk_slot),
    .chk_done(chk_done), .chk_allow(chk_allow), .chk_deny(chk_deny));

  // ************************************************************
  // common tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("counts: %0d compares, %0d n_errors", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  // bounded wait for hready high at a rising edge; answer of that edge
  task automatic wait_rdy(output logic [31:0] rd, output logic rsp);
    logic rdy;
    for (int i = 0; i < 20; i++)
    begin
      @(negedge hclk);
      {rdy, rsp, rd} = {hreadyout, hresp, hrdata};
      @(posedge hclk);
      if (rdy === 1'b1)
        return;
    end
    check({31'h0, hreadyout}, 32'h1);
  endtask : wait_rdy

  // one word transfer
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     input logic [1:0] m, output logic [31:0] rd, output logic rsp);
    @(posedge hclk);
    hsel    <= 1'b1;
    haddr   <= {22'h000000, idx, 2'b00};
    htrans  <= pag_pkg::HTRANS_NONSEQ;
    hwrite  <= w;
    hmaster <= m;
    wait_rdy(rd, rsp);
    hsel    <= 1'b0;
    htrans  <= 2'b00;
    hwdata  <= {24'h000000, d};
    wait_rdy(rd, rsp);
    hwdata  <= ~{24'h000000, d};
  endtask : bus

  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] m,
                    input logic e);
    logic [31:0] rd;
    logic        r;
    bus(1'b1, i, d, m, rd, r);
    check({31'h0, r}, {31'h0, e});
  endtask : wr

  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    logic [31:0] rd;
    logic        r;
    bus(1'b0, i, 8'h00, 2'h0, rd, r);
    check(rd, {24'h000000, e});
  endtask : rdc

  task automatic chk_ref(input logic [1:0] m, input logic s, input logic f, input logic w,
                         input logic [3:0] rg, input logic sv, input logic [4:0] sl,
                         input logic al);
    logic [2:0] ans;
    u_mst.issue(m, s, f, w, rg, sv, sl, ans);
    check({29'h0, ans}, al ? 32'h6 : 32'h5);
  endtask : chk_ref

  task automatic irq_is(input logic e);
    @(negedge hclk);
    check({31'h0, irq}, {31'h0, e});
  endtask : irq_is

  task automatic do_reset;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : do_reset

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    foreach (REGS[i]) rdc(REGS[i], i == 0 ? 8'h05 : 8'h00);
    wr(8'h29, 8'hff, 2'h0, 1'b0);
    rdc(8'h29, 8'h00);
    chk_ref(2'h0, 1'b0, 1'b0, 1'b0, 4'h0, 1'b1, 5'd3, 1'b0);
    chk_ref(2'h0, 1'b1, 1'b0, 1'b1, 4'h0, 1'b1, 5'd3, 1'b1);
    chk_ref(2'h0, 1'b1, 1'b1, 1'b0, 4'h0, 1'b1, 5'd3, 1'b0);
    chk_ref(2'h0, 1'b1, 1'b0, 1'b1, 4'h0, 1'b0, 5'd0, 1'b1);
    chk_ref(2'h0, 1'b0, 1'b0, 1'b0, 4'h1, 1'b0, 5'd0, 1'b0);
    chk_ref(2'h0, 1'b1, 1'b0, 1'b0, 4'h5, 1'b0, 5'd0, 1'b0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_codes;
    logic [2:0] cc;
    for (int c = 0; c < 8; c++)
    begin
      cc = c[2:0];
      wr(8'h24, {1'b0, cc, 1'b0, ~cc}, 2'h0, 1'b0);
      for (int k = 0; k < 4; k++)
      begin
        chk_ref(2'h0, k[1], 1'b0, ~k[0], 4'h0, 1'b1, 5'd0, PA_EXP[c][k]);
        chk_ref(2'h0, k[1], 1'b0, ~k[0], 4'h0, 1'b1, 5'd1, PA_EXP[7 - c][k]);
      end
    end
    wr(8'h24, 8'h00, 2'h0, 1'b0);
    $display("test codes done");
  endtask : t_codes

  task automatic t_group;
    logic [3:0] cc;
    for (int c = 0; c < 16; c++)
    begin
      cc = c[3:0];
      wr(8'h30, {4'h7, cc}, 2'h0, 1'b0);
      rdc(8'h30, {4'h0, cc});
      for (int k = 0; k < 6; k++)
        chk_ref(2'h0, k >= 3, k % 3 == 0, k % 3 == 1, 4'h0, 1'b0, 5'd0, GP_EXP[c][k]);
    end
    wr(8'h30, 8'h00, 2'h0, 1'b0);
    $display("test group done");
  endtask : t_group

  task automatic t_priv;
    chk_ref(2'h1, 1'b1, 1'b0, 1'b0, 4'h0, 1'b1, 5'd0, 1'b0);
    chk_ref(2'h2, 1'b1, 1'b0, 1'b0, 4'h0, 1'b1, 5'd0, 1'b1);
    wr(8'h20, 8'hf4, 2'h0, 1'b0);
    rdc(8'h20, 8'h04);
    chk_ref(2'h0, 1'b1, 1'b0, 1'b0, 4'h0, 1'b1, 5'd0, 1'b0);
    wr(8'h20, 8'h05, 2'h2, 1'b0);
    rdc(8'h20, 8'h05);
    wr(8'h26, 8'h44, 2'h1, 1'b1);
    rdc(8'h26, 8'h00);
    wr(8'h20, 8'h0f, 2'h3, 1'b1);
    rdc(8'h20, 8'h05);
    $display("test privilege done");
  endtask : t_priv

  task automatic t_irq;
    irq_is(1'b0);
    rdc(8'h40, 8'h03);
    wr(8'h40, 8'h03, 2'h1, 1'b1);
    wr(8'h40, 8'h03, 2'h0, 1'b0);
    rdc(8'h40, 8'h00);
    irq_is(1'b0);
    wr(8'h41, 8'h01, 2'h0, 1'b0);
    chk_ref(2'h3, 1'b0, 1'b0, 1'b0, 4'h0, 1'b1, 5'd0, 1'b0);
    rdc(8'h40, 8'h01);
    irq_is(1'b1);
    wr(8'h40, 8'h01, 2'h0, 1'b0);
    irq_is(1'b0);
    wr(8'h41, 8'h00, 2'h0, 1'b0);
    irq_is(1'b0);
    $display("test interrupt done");
  endtask : t_irq

  task automatic t_lock;
    wr(8'h27, 8'h0a, 2'h0, 1'b0);
    chk_ref(2'h0, 1'b0, 1'b0, 1'b0, 4'h0, 1'b1, 5'd7, 1'b1);
    wr(8'h27, 8'h40, 2'h0, 1'b1);
    rdc(8'h27, 8'h0a);
    wr(8'h31, 8'h8c, 2'h0, 1'b0);
    wr(8'h31, 8'h00, 2'h0, 1'b1);
    rdc(8'h31, 8'h8c);
    chk_ref(2'h1, 1'b0, 1'b1, 1'b0, 4'h1, 1'b0, 5'd0, 1'b1);
    do_reset();
    rdc(8'h27, 8'h00);
    rdc(8'h31, 8'h00);
    rdc(8'h20, 8'h05);
    $display("test lock done");
  endtask : t_lock

  // ************************************************************
  // clock, reset, main sequence and watchdog
  // ************************************************************
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // straps trust master 2; run the scenarios
  initial
  begin
    n_errors = 0;
    compares = 0;
    hresetn = 1'b0;
    {hsel, hwrite, htrans, hmaster, haddr, hwdata} = '0;
    hsize = pag_pkg::HSIZE_WORD;
    trust_strap = 3'b010;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_codes();
    t_group();
    t_priv();
    t_irq();
    t_lock();
    end_sim();
  end

  // cut a hang short
  initial
  begin
    #100us;
    n_errors++;
    end_sim();
  end
endmodule : pag_guard_tb

bind pag_guard pag_guard_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .chk_valid(chk_valid), .chk_fetch(chk_fetch),
  .chk_region(chk_region), .chk_slot_valid(chk_slot_valid), .chk_done(chk_done),
  .chk_allow(chk_allow), .chk_deny(chk_deny));
